// ---- design/bsq_sequencer.sv ----
`timescale 1ns/100ps
// Contract
// - Step once on enable rising, no reset
// - Reset overrides enable always
// - Reset loads preset step, else one
// - Reset clears array except step bit
// - Advance: clear old, move, set new
// - Direction high increments, low decrements
// - Without array step number changes, array holds
// - State in step, length, control words
// - Control word holds last enable, ok
// - Ok follows enable every evaluation
module bsq_sequencer #(
    parameter int ARRAY_BITS = bsq_pkg::ARRAY_BITS
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_sweep,
    input wire logic i_enable,
    input wire logic i_seq_reset,
    input wire logic i_dir_up,
    input wire logic i_preset_valid,
    input wire logic [15:0] i_preset_step,
    input wire logic i_array_attached,
    input wire logic i_len_wr,
    input wire logic [15:0] i_len_wdata,
    output logic o_ok,
    output logic [15:0] o_current_step_word,
    output logic [15:0] o_sequence_length_word,
    output logic [15:0] o_control_state_word,
    output logic [ARRAY_BITS-1:0] o_bit_array_base
);
    logic [15:0] step_reg;
    logic [15:0] len_reg;
    logic [15:0] ctrl_reg;
    logic [ARRAY_BITS-1:0] arr_reg;
    logic ok_reg;
    logic advance;
    logic [15:0] step_next;
    logic [15:0] load_step;
    logic [ARRAY_BITS-1:0] arr_next;

    assign advance = i_sweep && i_enable && !ctrl_reg[bsq_pkg::CTRL_EN_BIT] && !i_seq_reset;
    assign load_step = i_preset_valid ? i_preset_step : bsq_pkg::STEP_DEFAULT;

    always_comb begin
        step_next = step_reg;
        if (i_dir_up) begin
            if (step_reg >= len_reg) begin
                step_next = 16'h0001;
            end else begin
                step_next = step_reg + 16'h0001;
            end
        end else begin
            if (step_reg <= 16'h0001) begin
                step_next = len_reg;
            end else begin
                step_next = step_reg - 16'h0001;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            step_reg <= bsq_pkg::STEP_DEFAULT;
        end else if (i_sweep && i_seq_reset) begin
            step_reg <= load_step;
        end else if (advance) begin
            step_reg <= step_next;
        end
    end

    // Length stays writable; zero would trap wrap so keep it
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            len_reg <= bsq_pkg::LEN_RESET;
        end else if (i_len_wr && i_len_wdata != 16'h0000) begin
            len_reg <= i_len_wdata;
        end
    end

    // Array bits; indices beyond the array are ignored
    for (genvar gi = 0; gi < ARRAY_BITS; gi++) begin : g_arr
        localparam logic [15:0] BIT_STEP = 16'(gi + 1);
        logic bit_next;
        always_comb begin
            bit_next = arr_reg[gi];
            if (i_sweep && i_seq_reset) begin
                bit_next = (load_step == BIT_STEP);
            end else if (advance) begin
                if (step_next == BIT_STEP) begin
                    bit_next = 1'b1;
                end else if (step_reg == BIT_STEP) begin
                    bit_next = 1'b0;
                end
            end
        end
        assign arr_next[gi] = bit_next;
    end

    // Set wins when old and new step coincide
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            arr_reg <= '0;
        end else if (i_array_attached) begin
            arr_reg <= arr_next;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl_reg <= bsq_pkg::CTRL_RESET;
            ok_reg <= 1'b0;
        end else if (i_sweep) begin
            ctrl_reg <= bsq_pkg::CTRL_RESET;
            ctrl_reg[bsq_pkg::CTRL_EN_BIT] <= i_enable;
            ctrl_reg[bsq_pkg::CTRL_OK_BIT] <= i_enable;
            ctrl_reg[bsq_pkg::CTRL_RST_BIT] <= i_seq_reset;
            ctrl_reg[bsq_pkg::CTRL_DIR_BIT] <= i_dir_up;
            ok_reg <= i_enable;
        end
    end

    assign o_ok = ok_reg;
    assign o_current_step_word = step_reg;
    assign o_sequence_length_word = len_reg;
    assign o_control_state_word = ctrl_reg;
    assign o_bit_array_base = arr_reg;

    property p_rise_step;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (advance && i_dir_up && step_reg < len_reg) |=> step_reg == $past(step_reg) + 16'h0001;
    endproperty
    a_rise_step: assert property (p_rise_step) else $error("step not incremented");

    property p_reset_load;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_sweep && i_seq_reset) |=> step_reg == $past(load_step);
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("reset load wrong");

    property p_no_step_held;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_sweep && !i_seq_reset && ctrl_reg[bsq_pkg::CTRL_EN_BIT]) |=> $stable(step_reg);
    endproperty
    a_no_step_held: assert property (p_no_step_held) else $error("stepped while held");

    property p_down;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (advance && !i_dir_up && step_reg > 16'h0001) |=> step_reg == $past(step_reg) - 16'h0001;
    endproperty
    a_down: assert property (p_down) else $error("step not decremented");

    property p_wrap_up;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (advance && i_dir_up && step_reg >= len_reg) |=> step_reg == 16'h0001;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("no wrap to one");

    property p_ok;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_sweep |=> o_ok == $past(i_enable);
    endproperty
    a_ok: assert property (p_ok) else $error("ok not following enable");

    property p_no_array;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_array_attached |=> $stable(arr_reg);
    endproperty
    a_no_array: assert property (p_no_array) else $error("array touched");

    property p_onehot;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_sweep && i_seq_reset && i_array_attached && load_step == 16'h0001)
            |=> arr_reg == ARRAY_BITS'(1);
    endproperty
    a_onehot: assert property (p_onehot) else $error("array not one-hot");

    property p_ctrl_en;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_sweep |=> ctrl_reg[bsq_pkg::CTRL_EN_BIT] == $past(i_enable);
    endproperty
    a_ctrl_en: assert property (p_ctrl_en) else $error("enable not recorded");

    property p_ctrl_ok;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_sweep |=> ctrl_reg[bsq_pkg::CTRL_OK_BIT] == $past(i_enable);
    endproperty
    a_ctrl_ok: assert property (p_ctrl_ok) else $error("ok not recorded");

    property p_idle;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_sweep |=> $stable(step_reg) && $stable(arr_reg) && $stable(ctrl_reg);
    endproperty
    a_idle: assert property (p_idle) else $error("changed without sweep");

    property p_arr_keep;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_sweep && !i_seq_reset && !advance) |=> $stable(arr_reg);
    endproperty
    a_arr_keep: assert property (p_arr_keep) else $error("array moved while idle");

    property p_wrap_down;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (advance && !i_dir_up && step_reg <= 16'h0001) |=> step_reg == $past(len_reg);
    endproperty
    a_wrap_down: assert property (p_wrap_down) else $error("no wrap to length");

    property p_set_new;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (advance && i_array_attached && step_next == 16'h0001) |=> arr_reg[0];
    endproperty
    a_set_new: assert property (p_set_new) else $error("new step bit not set");

    property p_clear_old;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (advance && i_array_attached && step_reg == 16'h0001 && step_next != 16'h0001)
            |=> !arr_reg[0];
    endproperty
    a_clear_old: assert property (p_clear_old) else $error("old step bit kept");

    property p_len_keep;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_len_wr && i_len_wdata == 16'h0000) |=> $stable(len_reg);
    endproperty
    a_len_keep: assert property (p_len_keep) else $error("zero length taken");

    c_advance_up: cover property (@(posedge i_ref_clk) advance && i_dir_up);
    c_advance_down: cover property (@(posedge i_ref_clk) advance && !i_dir_up);
    c_reset: cover property (@(posedge i_ref_clk) i_sweep && i_seq_reset && i_enable);
    c_wrap_down: cover property (@(posedge i_ref_clk) advance && !i_dir_up && step_reg <= 16'h0001);
    c_no_array: cover property (@(posedge i_ref_clk) advance && !i_array_attached);
endmodule : bsq_sequencer

// ---- include/bsq_pkg.sv ----
package bsq_pkg;
    localparam int STEP_W = 16;
    localparam logic [15:0] STEP_DEFAULT = 16'h0001;
    localparam logic [15:0] LEN_RESET = 16'h0010;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Control word bit positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_OK_BIT = 1;
    localparam int CTRL_RST_BIT = 2;
    localparam int CTRL_DIR_BIT = 3;
    localparam int ARRAY_BITS = 16;
endpackage : bsq_pkg

// ---- verif/bsq_prog_model.sv ----
`timescale 1ns/100ps
// Controlling program: one evaluation strobe per request, repeating every other cycle while held
module bsq_prog_model (
    input wire logic i_ref_clk,
    input wire logic i_go,
    output logic o_sweep
);
    // Strobe lasts one cycle even if the request is held
    always_ff @(posedge i_ref_clk) begin
        o_sweep <= i_go && !o_sweep;
    end
endmodule : bsq_prog_model

// ---- verif/test_bsq_sequencer.sv ----
`timescale 1ns/100ps
module test_bsq_sequencer;
    logic clk = 0, rst = 1, en = 0, sr = 0, dir = 0, pv = 0, att = 0, lw = 0, go = 0, sw, ok;
    logic [15:0] ps = 16'h0000, ld = 16'h0000, st, ln, cw, ar;
    logic [15:0] e_st = 16'h0001, e_ln = 16'h0010, e_ar = 16'h0000;
    logic e_en = 0;
    logic [31:0] r;
    int fails = 0, check_count = 0, cyc = 0, seed = 32'h2c4b5720;
    always #20 clk = ~clk;
    bsq_prog_model i_prog (.i_ref_clk(clk), .i_go(go), .o_sweep(sw));
    bsq_sequencer i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_sweep(sw), .i_enable(en),
        .i_seq_reset(sr), .i_dir_up(dir), .i_preset_valid(pv), .i_preset_step(ps),
        .i_array_attached(att), .i_len_wr(lw), .i_len_wdata(ld), .o_ok(ok),
        .o_current_step_word(st), .o_sequence_length_word(ln),
        .o_control_state_word(cw), .o_bit_array_base(ar));
    function automatic logic [15:0] nxt(input logic [15:0] s, input logic up);
        if (up) return (s >= e_ln) ? 16'h0001 : s + 16'h0001;
        return (s <= 16'h0001) ? e_ln : s - 16'h0001;
    endfunction : nxt
    function automatic logic [15:0] onehot(input logic [15:0] s);
        return (s >= 16'h0001 && s <= 16'h0010) ? 16'h0001 << (s - 16'h0001) : 16'h0000;
    endfunction : onehot
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t flag got %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic sweep(input logic e, rs, d, a, p, input logic [15:0] pstep);
        @(posedge clk) #1;
        {en, sr, dir, att, pv, ps, go} = {e, rs, d, a, p, pstep, 1'b1};
        @(posedge clk) #1 go = 0;
        @(posedge clk) #1;
        if (rs) begin
            e_st = p ? pstep : 16'h0001;
            if (a) e_ar = onehot(e_st);
        end else if (e && !e_en) begin
            if (a) e_ar &= ~onehot(e_st);
            e_st = nxt(e_st, d);
            if (a) e_ar |= onehot(e_st);
        end
        e_en = e;
        chk(st, e_st);
        chk(ar, e_ar);
        chk_bit(ok, e);
        chk(cw, {12'h000, d, rs, e, e});
        chk(ln, e_ln);
    endtask : sweep
    task automatic setlen(input logic [15:0] v);
        @(posedge clk) #1 {lw, ld} = {1'b1, v};
        @(posedge clk) #1 lw = 0;
        if (v != 16'h0000) e_ln = v;
        chk(ln, e_ln);
    endtask : setlen
    task automatic results;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 0;
        chk(st, e_st);
        chk(ln, e_ln);
        chk(ar, e_ar);
        chk(cw, 16'h0000);
        chk_bit(ok, 1'b0);
        sweep(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0007);
        sweep(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        sweep(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000);
        sweep(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0003);
        // Mid-run reset must restore every word
        @(posedge clk) #1 rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        {e_st, e_ln, e_ar, e_en} = {16'h0001, 16'h0010, 16'h0000, 1'b0};
        chk(st, e_st);
        chk(ln, e_ln);
        chk(ar, e_ar);
        chk(cw, 16'h0000);
        chk_bit(ok, 1'b0);
        // Enable rises together with reset
        sweep(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0009);
        setlen(16'h0000);
        setlen(16'h0005);
        repeat (300) begin
            if (check_count > 700 && e_ln != 16'h0010) setlen(16'h0010);
            r = $random(seed);
            sweep(r[0], r[4:2] == 3'h0, r[5], r[7:6] != 2'h0, r[8],
                16'h0001 + {12'h000, r[12:9]} % e_ln);
        end
        results;
    end
endmodule : test_bsq_sequencer
